// ===== rtl/pmw_pkg.sv
// Package: register map, fields, timing and types of the power-mode block
package pmw_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [4:0] ADR_SYS_MODE  = 5'h00;
    localparam logic [4:0] ADR_CTRL      = 5'h04;
    localparam logic [4:0] ADR_WAKE_EN   = 5'h08;
    localparam logic [4:0] ADR_PWR_CFG   = 5'h0C;
    localparam int         ADR_W         = 5;
    // system_mode_register fields
    localparam int         F_FAST_SEL    = 0;
    localparam int         F_IDLE_SEL    = 1;
    localparam int         F_FAST_RDY    = 2;
    localparam int         F_SLOW_RDY    = 3;
    localparam int         F_DIV_LO      = 5;
    localparam int         F_DIV_HI      = 7;
    localparam logic [7:0] SYS_MODE_RST  = 8'h03;
    // Control register field
    localparam int         F_SYSCLK_KEEP = 7;
    // Power configuration register fields
    localparam int         F_WDT_EN      = 0;
    localparam int         F_LVD_EN      = 1;
    localparam int         F_SLOW_XTAL   = 2;
    localparam int         F_PDF         = 4;
    localparam int         F_TO          = 5;
    localparam int         F_MODE_LO     = 8;
    localparam int         F_MODE_HI     = 10;
    localparam logic [7:0] PWR_CFG_RST   = 8'h01;
    // Divider select codes
    localparam logic [2:0] DIV_SUB_A     = 3'h0;
    localparam logic [2:0] DIV_SUB_B     = 3'h1;
    // Timing
    localparam int         CLK_HZ        = 125000000;
    localparam int         SLOW_OSC_HZ   = 32768;
    localparam int         SLOW_DIV      = CLK_HZ / SLOW_OSC_HZ;
    localparam int         XTAL_TICKS    = 1024;
    localparam int         IRC_TICKS     = 2;
    localparam int         FAST_SETTLE   = 64;
    localparam int         CNT_W         = 12;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_IDLE0  = 3'b001,
        ST_IDLE1  = 3'b010,
        ST_SLEEP0 = 3'b011,
        ST_SLEEP1 = 3'b100
    } pwr_state_t;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_SLOW   = 3'b001,
        MODE_IDLE0  = 3'b010,
        MODE_IDLE1  = 3'b011,
        MODE_SLEEP0 = 3'b100,
        MODE_SLEEP1 = 3'b101
    } op_mode_t;

    // Clock enables handed to the rest of the chip
    typedef struct packed {
        logic sys;
        logic fast_osc;
        logic sub;
        logic tbc;
        logic wdt;
    } clk_gate_t;

    // Wake-up outcome pulses toward the CPU core
    typedef struct packed {
        logic resume;
        logic irq_service;
        logic pc_sp_reset;
    } wake_evt_t;
endpackage

// ===== rtl/power_mode_wakeup_controller.sv
// Power-mode and wake-up controller with a Wishbone register slave
//
// Summary of operation
// - source clear, divider 000/001 selects slow clock
// - source set or divider 010-111 returns NORMAL
// - slow clock stops fast oscillator and dividers
// - slow switch completes only with slow oscillator ready
// - halt, idle 0, watchdog/detector off enters SLEEP0
// - halt, idle 0, watchdog or detector on: SLEEP1
// - halt, idle 1, keep 0 enters IDLE0
// - halt, idle 1, keep 1 enters IDLE1
// - low-power states hold CPU and state intact
// - SLEEP1/IDLE entry clears watchdog, runs if enabled
// - halt sets power-down flag, clears expired flag
// - wake on port A fall, interrupt, watchdog overflow
// - overflow wake sets expired, resets only PC/SP
// - power-down flag cleared by reset or watchdog clear
// - per-pin port A wake enable, resume after halt
// - disabled or stack-full interrupt resumes after halt
// - enabled interrupt with free stack is serviced, unless port A or watchdog wakes in the same cycle
// - interrupt pending before entry cannot wake
// - divider 010-111 gives fast/64 down to fast/2
// - fast ready low in SLEEP/IDLE0, rises when settled
// - slow ready after 1024 crystal or 1-2 internal cycles
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module power_mode_wakeup_controller
    import pmw_pkg::*;
#(
    parameter int PORT_W       = 8,
    parameter int IRQ_W        = 4,
    parameter int SLOW_DIV_CNT = SLOW_DIV,
    parameter int FAST_CYCLES  = FAST_SETTLE
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADR_W-1:0]  adr_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    input  wire logic [3:0]        sel_i,
    input  wire logic              we_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    output logic                   ack_o,
    input  wire logic              halt_i,
    input  wire logic              clr_wdt_i,
    input  wire logic              wdt_overflow_i,
    input  wire logic [PORT_W-1:0] port_a_i,
    input  wire logic [IRQ_W-1:0]  irq_req_i,
    input  wire logic [IRQ_W-1:0]  irq_en_i,
    input  wire logic              stack_full_i,
    output clk_gate_t              clk_gate_o,
    output logic                   wdt_clear_o,
    output logic                   cpu_hold_o,
    output wake_evt_t              wake_o,
    output op_mode_t               mode_o
);
    // Software-visible state
    logic [2:0]        clock_divider_select;
    logic              fast_clock_select;
    logic              halt_idle_select;
    logic              idle_sysclk_keep;
    logic [PORT_W-1:0] port_a_wake_enable;
    logic              wdt_enable;
    logic              lvd_enable;
    logic              slow_xtal;
    logic              power_down_flag;
    logic              watchdog_expired_flag;
    logic              fast_osc_ready;
    logic              slow_osc_ready;
    // Internal state
    pwr_state_t        state;
    pwr_state_t        next_state;
    logic              on_slow;
    logic [5:0]        fast_div;
    logic [CNT_W-1:0]  slow_div;
    logic [CNT_W-1:0]  fast_cnt;
    logic [CNT_W-1:0]  slow_cnt;
    logic [PORT_W-1:0] port_a_prev;
    logic [IRQ_W-1:0]  irq_armed;
    logic              want_slow;
    logic              halt_take;
    logic              low_power;
    logic              slow_tick;
    logic              fast_tick;
    logic              pa_wake;
    logic              irq_wake;
    logic              wdt_wake;
    logic              any_wake;
    logic              wr_en;
    logic              rd_sel;
    clk_gate_t         gate;

    // Divider select to count mask; all ones for the chosen ratio
    function automatic logic [5:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h2:    div_mask = 6'h3F;
            3'h3:    div_mask = 6'h1F;
            3'h4:    div_mask = 6'h0F;
            3'h5:    div_mask = 6'h07;
            3'h6:    div_mask = 6'h03;
            3'h7:    div_mask = 6'h01;
            default: div_mask = 6'h00;
        endcase
    endfunction

    // Request decode shared by the slave processes
    assign wr_en = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
    assign rd_sel = cyc_i & stb_i & ~we_i & ~ack_o;

    // Slow request: source bit clear with a sub-clock divider code
    assign want_slow = ~fast_clock_select &
        ((clock_divider_select == DIV_SUB_A) |
         (clock_divider_select == DIV_SUB_B));
    assign low_power = (state != ST_RUN);
    assign halt_take = halt_i & ~low_power;

    // Single-cycle answer; ack drops the cycle after it rose
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
        end
    end

    // Read mux; unmapped addresses read zero but still ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_sel) begin
            dat_o <= 32'h0000_0000;
            case (adr_i)
                ADR_SYS_MODE: begin
                    dat_o[F_DIV_HI:F_DIV_LO] <= clock_divider_select;
                    dat_o[F_SLOW_RDY]        <= slow_osc_ready;
                    dat_o[F_FAST_RDY]        <= fast_osc_ready;
                    dat_o[F_IDLE_SEL]        <= halt_idle_select;
                    dat_o[F_FAST_SEL]        <= fast_clock_select;
                end
                ADR_CTRL: dat_o[F_SYSCLK_KEEP] <= idle_sysclk_keep;
                ADR_WAKE_EN: dat_o[PORT_W-1:0] <= port_a_wake_enable;
                ADR_PWR_CFG: begin
                    dat_o[F_WDT_EN]            <= wdt_enable;
                    dat_o[F_LVD_EN]            <= lvd_enable;
                    dat_o[F_SLOW_XTAL]         <= slow_xtal;
                    dat_o[F_PDF]               <= power_down_flag;
                    dat_o[F_TO]                <= watchdog_expired_flag;
                    dat_o[F_MODE_HI:F_MODE_LO] <= mode_o;
                end
                default: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Writable control fields; only byte lane 0 carries them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_divider_select <= SYS_MODE_RST[F_DIV_HI:F_DIV_LO];
            halt_idle_select     <= SYS_MODE_RST[F_IDLE_SEL];
            fast_clock_select    <= SYS_MODE_RST[F_FAST_SEL];
            idle_sysclk_keep     <= 1'b0;
            port_a_wake_enable   <= '0;
            wdt_enable           <= PWR_CFG_RST[F_WDT_EN];
            lvd_enable           <= PWR_CFG_RST[F_LVD_EN];
            slow_xtal            <= PWR_CFG_RST[F_SLOW_XTAL];
        end else if (wr_en) begin
            case (adr_i)
                ADR_SYS_MODE: begin
                    clock_divider_select <= dat_i[F_DIV_HI:F_DIV_LO];
                    halt_idle_select     <= dat_i[F_IDLE_SEL];
                    fast_clock_select    <= dat_i[F_FAST_SEL];
                end
                ADR_CTRL: idle_sysclk_keep <= dat_i[F_SYSCLK_KEEP];
                ADR_WAKE_EN: port_a_wake_enable <= dat_i[PORT_W-1:0];
                ADR_PWR_CFG: begin
                    wdt_enable <= dat_i[F_WDT_EN];
                    lvd_enable <= dat_i[F_LVD_EN];
                    slow_xtal  <= dat_i[F_SLOW_XTAL];
                end
                default: ;
            endcase
        end
    end

    // Source switching; held still while the CPU is halted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_slow <= 1'b0;
        end else if (!low_power) begin
            if (!want_slow) begin
                on_slow <= 1'b0;
            end else if (slow_osc_ready) begin
                on_slow <= 1'b1;
            end
        end
    end

    // Halt decode into the four low-power states
    always_comb begin
        next_state = ST_RUN;
        if (halt_idle_select) begin
            next_state = idle_sysclk_keep ? ST_IDLE1
                                          : ST_IDLE0;
        end else if (wdt_enable | lvd_enable) begin
            next_state = ST_SLEEP1;
        end else begin
            next_state = ST_SLEEP0;
        end
    end

    // Power state; only a wake event leaves a low-power state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_RUN;
        end else begin
            case (state)
                ST_RUN: if (halt_i) state <= next_state;
                ST_IDLE0,
                ST_IDLE1,
                ST_SLEEP0,
                ST_SLEEP1: if (any_wake) state <= ST_RUN;
                default: state <= ST_RUN;
            endcase
        end
    end

    // Clock gating per state
    always_comb begin
        gate = '0;
        case (state)
            ST_RUN, ST_IDLE1: begin
                gate.fast_osc = ~on_slow;
                gate.sub      = 1'b1;
                gate.tbc      = 1'b1;
                gate.wdt      = wdt_enable;
            end
            ST_IDLE0: begin
                gate.sub = 1'b1;
                gate.tbc = 1'b1;
                gate.wdt = wdt_enable;
            end
            ST_SLEEP1: begin
                gate.sub = 1'b1;
                gate.wdt = wdt_enable;
            end
            default: gate = '0;
        endcase
        // System clock only runs in RUN and IDLE1
        gate.sys = (state == ST_RUN || state == ST_IDLE1) &
                   (on_slow ? slow_tick : fast_tick);
    end

    // Fast divider chain, stopped whenever the fast oscillator is off
    always_ff @(posedge clk_i) begin
        if (rst_i || !gate.fast_osc) begin
            fast_div <= 6'h00;
        end else begin
            fast_div <= fast_div + 6'h01;
        end
    end
    // Qualified by on_slow, not the gate, so the gate logic stays acyclic
    assign fast_tick = ~on_slow &
        (fast_clock_select ? 1'b1 :
         ((fast_div & div_mask(clock_divider_select)) ==
          div_mask(clock_divider_select)));

    // Slow oscillator model: one tick per slow period while enabled
    always_ff @(posedge clk_i) begin
        if (rst_i || !gate.sub) begin
            slow_div <= '0;
        end else if (slow_tick) begin
            slow_div <= '0;
        end else begin
            slow_div <= slow_div + 1'b1;
        end
    end
    // Divider is held at zero while stopped, so no gate term is needed
    assign slow_tick = (slow_div == CNT_W'(SLOW_DIV_CNT - 1));

    // Fast ready: cleared while the oscillator is off, then settles
    always_ff @(posedge clk_i) begin
        if (rst_i || !gate.fast_osc) begin
            fast_cnt       <= '0;
            fast_osc_ready <= 1'b0;
        end else if (fast_cnt == CNT_W'(FAST_CYCLES - 1)) begin
            fast_osc_ready <= 1'b1;
        end else begin
            fast_cnt <= fast_cnt + 1'b1;
        end
    end

    // Slow ready: crystal needs far more start-up than internal RC
    always_ff @(posedge clk_i) begin
        if (rst_i || !gate.sub) begin
            slow_cnt       <= '0;
            slow_osc_ready <= 1'b0;
        end else if (slow_tick) begin
            if (slow_cnt == (slow_xtal ? CNT_W'(XTAL_TICKS - 1)
                                       : CNT_W'(IRC_TICKS - 1))) begin
                slow_osc_ready <= 1'b1;
            end else begin
                slow_cnt <= slow_cnt + 1'b1;
            end
        end
    end

    // Wake sources; a pending request at entry is disarmed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_a_prev <= '0;
            irq_armed   <= '0;
        end else begin
            port_a_prev <= port_a_i;
            if (halt_take) begin
                irq_armed <= ~irq_req_i;
            end
        end
    end
    assign pa_wake  = |(port_a_prev & ~port_a_i &
                        port_a_wake_enable);
    assign irq_wake = |(irq_req_i & irq_armed);
    assign wdt_wake = wdt_overflow_i & gate.wdt;
    assign any_wake = low_power & (pa_wake | irq_wake | wdt_wake);

    // Wake outcome pulses; watchdog wake takes priority
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= '0;
        end else begin
            wake_o <= '0;
            if (any_wake) begin
                if (wdt_wake) begin
                    wake_o.pc_sp_reset <= 1'b1;
                end else if (!pa_wake &&
                             |(irq_req_i & irq_armed & irq_en_i) &&
                             !stack_full_i) begin
                    wake_o.irq_service <= 1'b1;
                end else begin
                    wake_o.resume <= 1'b1;
                end
            end
        end
    end

    // Watchdog clear on halt entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_clear_o <= 1'b0;
        end else begin
            wdt_clear_o <= halt_take;
        end
    end

    // Status flags; halt set beats a same-cycle watchdog clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_down_flag       <= 1'b0;
            watchdog_expired_flag <= 1'b0;
        end else begin
            if (halt_take) begin
                power_down_flag <= 1'b1;
            end else if (clr_wdt_i) begin
                power_down_flag <= 1'b0;
            end
            if (any_wake && wdt_wake) begin
                watchdog_expired_flag <= 1'b1;
            end else if (halt_take) begin
                watchdog_expired_flag <= 1'b0;
            end
        end
    end

    // Outputs
    assign clk_gate_o = gate;
    assign cpu_hold_o = low_power;
    always_comb begin
        case (state)
            ST_IDLE0:  mode_o = MODE_IDLE0;
            ST_IDLE1:  mode_o = MODE_IDLE1;
            ST_SLEEP0: mode_o = MODE_SLEEP0;
            ST_SLEEP1: mode_o = MODE_SLEEP1;
            default:   mode_o = on_slow ? MODE_SLOW : MODE_NORMAL;
        endcase
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_slow_needs_ready: assert property (
        $rose(on_slow) |-> $past(slow_osc_ready) && $past(want_slow))
        else $error("slow switch without ready slow oscillator");
    a_fast_return: assert property (
        !want_slow && !low_power |=> !on_slow)
        else $error("fast request not honoured");
    a_slow_kills_fast: assert property (
        on_slow |-> !clk_gate_o.fast_osc && !fast_tick)
        else $error("fast oscillator running on slow clock");
    a_sleep0_entry: assert property (
        halt_take && !halt_idle_select && !wdt_enable && !lvd_enable
        |=> state == ST_SLEEP0 && clk_gate_o == '0 && wdt_clear_o)
        else $error("SLEEP0 entry wrong");
    a_sleep1_entry: assert property (
        halt_take && !halt_idle_select && (wdt_enable || lvd_enable)
        |=> state == ST_SLEEP1 && clk_gate_o.sub && !clk_gate_o.tbc)
        else $error("SLEEP1 entry wrong");
    a_idle_entry: assert property (
        halt_take && halt_idle_select
        |=> (state == ST_IDLE1) == $past(idle_sysclk_keep)
            && clk_gate_o.tbc && cpu_hold_o)
        else $error("IDLE entry wrong");
    a_halt_flags: assert property (
        halt_take |=> power_down_flag && !watchdog_expired_flag)
        else $error("halt flags wrong");
    a_wdt_wake: assert property (
        any_wake && wdt_wake |=> wake_o.pc_sp_reset
            && watchdog_expired_flag && state == ST_RUN)
        else $error("watchdog wake wrong");
    a_stale_irq: assert property (
        halt_take ##1 (irq_req_i == $past(irq_req_i) && !pa_wake
            && !wdt_wake) |-> !any_wake)
        else $error("pre-pending interrupt woke device");
    a_fast_rdy_low: assert property (
        state == ST_IDLE0 || state == ST_SLEEP0 |-> ##1 !fast_osc_ready)
        else $error("fast ready high while stopped");
    a_pdf_clear: assert property (
        clr_wdt_i && !halt_take |=> !power_down_flag)
        else $error("power-down flag not cleared");

    c_slow_mode:  cover property ($rose(on_slow));
    c_idle1_irq:  cover property (state == ST_IDLE1 ##1 wake_o.irq_service);
    c_sleep0_pa:  cover property (state == ST_SLEEP0 ##1 wake_o.resume);
    c_sleep1_wdt: cover property (state == ST_SLEEP1 ##1 wake_o.pc_sp_reset);
endmodule

// ===== tb/cpu_core_model.sv
// CPU core model: issues halt pulses toward the power-mode block
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic halt_req_i,
    input  wire logic cpu_hold_i,
    output logic      halt_o
);
    // One-cycle halt; a held core executes nothing, so no halt then
    always_ff @(posedge clk_i) begin
        if (rst_i)
            halt_o <= 1'b0;
        else
            halt_o <= halt_req_i && !cpu_hold_i && !halt_o;
    end
endmodule

// ===== tb/tb_power_mode_wakeup_controller.sv
// Self-checking testbench for the power-mode and wake-up controller
`timescale 1ns/1ps
module tb_power_mode_wakeup_controller;
    import pmw_pkg::*;
    logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
    logic        halt_req = 0, clr_wdt_i = 0, wdt_overflow_i = 0;
    logic        stack_full_i = 0, ack_o, halt_i, wdt_clear_o, cpu_hold_o;
    logic [4:0]  adr_i = '0;
    logic [31:0] dat_i = '0, dat_o, rd;
    logic [3:0]  sel_i = 4'hF, irq_req_i = '0, irq_en_i = '0, c;
    logic [7:0]  port_a_i = 8'hFF, pin;
    clk_gate_t   clk_gate_o;
    wake_evt_t   wake_o;
    op_mode_t    mode_o;
    int          fail_count = 0, checks = 0, cycles = 0, n, d;
    localparam logic [3:0] CASES [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'hC};

    power_mode_wakeup_controller #(.SLOW_DIV_CNT(4), .FAST_CYCLES(4))
        power_mode_wakeup_controller_i (.clk_i, .rst_i, .adr_i, .dat_i,
        .dat_o, .sel_i, .we_i, .cyc_i, .stb_i, .ack_o, .halt_i, .clr_wdt_i,
        .wdt_overflow_i, .port_a_i, .irq_req_i, .irq_en_i, .stack_full_i,
        .clk_gate_o, .wdt_clear_o, .cpu_hold_o, .wake_o, .mode_o);
    cpu_core_model cpu_core_model_i (.clk_i, .rst_i, .halt_req_i(halt_req),
        .cpu_hold_i(cpu_hold_o), .halt_o(halt_i));

    always #4 clk_i = ~clk_i;
    // Hang guard; the whole run needs a few thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle; no latency assumed, only the hang guard ends a wait
    task wb(input logic w, input logic [4:0] a, input logic [31:0] dw);
        @(posedge clk_i);
        we_i <= w; adr_i <= a; dat_i <= dw; cyc_i <= 1; stb_i <= 1;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 0; stb_i <= 0;
    endtask
    task wait_hold(input logic v);
        n = 0;
        while (cpu_hold_o !== v && n < 300) begin @(posedge clk_i); n++; end
    endtask
    task halt_now;
        @(posedge clk_i) halt_req <= 1;
        @(posedge clk_i) halt_req <= 0;
        wait_hold(1);
        chk(wdt_clear_o, 1);
    endtask
    task complete_run;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Code c = {idle select, keep, detector, watchdog}
    function automatic op_mode_t exp_mode(input logic [3:0] m);
        if (m[3]) return m[2] ? MODE_IDLE1 : MODE_IDLE0;
        return (m[1] | m[0]) ? MODE_SLEEP1 : MODE_SLEEP0;
    endfunction

    initial begin
        void'($urandom(32'hab22));
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        wb(0, ADR_SYS_MODE, 0); chk(rd & 32'hF3, SYS_MODE_RST);
        wb(0, ADR_PWR_CFG, 0);  chk(rd & 32'h37, PWR_CFG_RST);
        wb(1, 5'h10, 32'hFF);   wb(0, 5'h10, 0); chk(rd, 0);
        $display("test reset done");
        // Slow entry needs the slow oscillator settled first
        wb(1, ADR_SYS_MODE, {24'h0, 3'($urandom_range(1, 0)), 5'h0});
        n = 0;
        while (mode_o !== MODE_SLOW && n < 300) begin @(posedge clk_i); n++; end
        chk(mode_o, MODE_SLOW);
        chk(clk_gate_o.fast_osc, 0);
        d = $urandom_range(7, 2);
        wb(1, ADR_SYS_MODE, {24'h0, 3'(d), 5'h0});
        // Source flop follows the stored divider one cycle later
        @(posedge clk_i);
        chk(mode_o, MODE_NORMAL);
        n = 0;
        do begin wb(0, ADR_SYS_MODE, 0); n++; end while (!rd[2] && n < 40);
        chk(rd[2], 1);
        n = 0;
        repeat (128) @(posedge clk_i) n += clk_gate_o.sys;
        chk(n, 128 >> (8 - d));
        $display("test clock switch done");
        // Overflow while asleep with the watchdog running
        wb(1, ADR_SYS_MODE, 32'h01);
        wb(1, ADR_PWR_CFG, 32'h01);
        halt_now;
        @(posedge clk_i) wdt_overflow_i <= 1;
        @(posedge clk_i) wdt_overflow_i <= 0;
        wait_hold(0);
        chk(wake_o, 3'b001);
        wb(0, ADR_PWR_CFG, 0); chk(rd[5:4], 2'b11);
        $display("test watchdog wake done");
        // Every low-power state, woken by one enabled port pin
        foreach (CASES[i]) begin
            c = CASES[i];
            if (!c[3]) c[2] = 1'($urandom_range(1, 0));
            pin = 8'h01 << $urandom_range(7, 0);
            wb(1, ADR_PWR_CFG, {30'h0, c[1:0]});
            wb(1, ADR_CTRL, {24'h0, c[2], 7'h0});
            wb(1, ADR_SYS_MODE, {30'h0, c[3], 1'b1});
            wb(1, ADR_WAKE_EN, {24'h0, pin});
            halt_now;
            chk(mode_o, exp_mode(c));
            chk({clk_gate_o.sub, clk_gate_o.tbc},
                c[3] ? 2'b11 : {c[1] | c[0], 1'b0});
            chk(clk_gate_o.wdt, c[0]);
            wb(0, ADR_PWR_CFG, 0);
            chk(rd[10:4], {exp_mode(c), 4'h1});
            if (c == 4'h0) begin
                @(posedge clk_i) wdt_overflow_i <= 1;
                @(posedge clk_i) wdt_overflow_i <= 0;
            end
            @(posedge clk_i) port_a_i <= ~{pin[6:0], pin[7]};
            repeat (5) @(posedge clk_i);
            chk(cpu_hold_o, 1);
            port_a_i <= 8'h00;
            wait_hold(0);
            chk(wake_o, 3'b100);
            port_a_i <= 8'hFF;
            wb(0, ADR_PWR_CFG, 0); chk(rd[4], 1);
            @(posedge clk_i) clr_wdt_i <= 1;
            @(posedge clk_i) clr_wdt_i <= 0;
            wb(0, ADR_PWR_CFG, 0); chk(rd[4], 0);
        end
        $display("test halt states done");
        // Crystal start-up after SLEEP0 takes the long count
        wb(1, ADR_PWR_CFG, 32'h04);
        wb(1, ADR_SYS_MODE, 32'h01);
        wb(1, ADR_WAKE_EN, 32'h01);
        halt_now;
        @(posedge clk_i) port_a_i <= 8'hFE;
        wait_hold(0);
        port_a_i <= 8'hFF;
        repeat (XTAL_TICKS * 3) @(posedge clk_i);
        wb(0, ADR_SYS_MODE, 0); chk(rd[3], 0);
        n = 0;
        do begin wb(0, ADR_SYS_MODE, 0); n++; end while (!rd[3] && n < 900);
        chk(rd[3], 1);
        $display("test crystal start-up done");
        // Pending request cannot wake; new one serviced or resumes
        for (int s = 0; s < 2; s++) begin
            wb(1, ADR_CTRL, 32'h80);
            wb(1, ADR_SYS_MODE, 32'h03);
            irq_req_i <= 4'b0001; irq_en_i <= 4'b0011; stack_full_i <= s[0];
            halt_now;
            repeat (5) @(posedge clk_i);
            chk(cpu_hold_o, 1);
            irq_req_i <= 4'b0011;
            wait_hold(0);
            chk(wake_o, s ? 3'b100 : 3'b010);
            irq_req_i <= 4'b0000;
        end
        $display("test interrupt wake done");
        complete_run;
    end
endmodule
